//--- tb/mfd_core_bench.sv
// Purpose: self-checking bench for mfd_core
// Assumes: two cycles per instruction, internal scratch only
// Notes:   behavioural model compared at every instruction slot
`timescale 1ns/1ps
`define chk(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end
module mfd_core_bench;
   logic                    i_mclk, i_rst_n, i_irq_enter, i_flag_wr, i_carry_in, i_zero_in;
   logic [mfd_pkg::IW-1:0]  i_instr;
   logic [mfd_pkg::PCW-1:0] o_pc, pc;
   logic [7:0]              o_port_addr, o_port_wdata, i_port_rdata, i_xmem_rdata;
   logic                    o_port_rd, o_port_wr, o_xmem_rd, o_xmem_wr, o_irq_ack, o_carry, o_zero;
   logic                    cy, zf, shc, shz, ack;
   logic [7:0]              regs [32];
   logic [7:0]              scr [32];
   logic [7:0]              pm [256];
   logic [9:0]              stk [16];
   logic [3:0]              sp;
   logic [31:0]             rng, r;
   int                      mismatches, check_count;
   ////////////////////////////////////////////////////////////////////////
   mfd_core #(.EXT_SCRATCH(1'b0)) u_mfd_core (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_pc(o_pc),
      .i_instr(i_instr), .o_port_addr(o_port_addr), .o_port_wdata(o_port_wdata),
      .o_port_rd(o_port_rd), .o_port_wr(o_port_wr), .i_port_rdata(i_port_rdata),
      .o_xmem_rd(o_xmem_rd), .o_xmem_wr(o_xmem_wr), .i_xmem_rdata(i_xmem_rdata),
      .i_irq_enter(i_irq_enter), .o_irq_ack(o_irq_ack), .i_flag_wr(i_flag_wr),
      .i_carry_in(i_carry_in), .i_zero_in(i_zero_in), .o_carry(o_carry), .o_zero(o_zero));
   mfd_periph u_mfd_periph (.i_mclk(i_mclk), .i_addr(o_port_addr), .i_wdata(o_port_wdata),
      .i_rd(o_port_rd), .i_wr(o_port_wr), .o_rdata(i_port_rdata), .o_xdata(i_xmem_rdata));
   ////////////////////////////////////////////////////////////////////////
   // xorshift source for stimulus
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // one instruction slot: drive, check, update the model
   task automatic run(input logic [17:0] ins, input logic fw = 1'b0, c = 1'b0, z = 1'b0,
                      input logic irq = 1'b0);
      logic [4:0]  rd, ix, si;
      logic [2:0]  sub;
      logic        io, call, ret;
      logic [7:0]  ad;
      logic [31:0] rb;
      rd = ins[12:8];
      ix = ins[7:3];
      sub = ins[2:0];
      io = ins[17:13] == mfd_pkg::OP_IO;
      call = ins[17:10] == mfd_pkg::OP_CALL || ins[17:10] == mfd_pkg::OP_CALL_NC;
      ret = ins[17:1] == mfd_pkg::OP_RET;
      rb = xs();
      i_instr <= ins;
      i_irq_enter <= irq;
      i_flag_wr <= fw | ((io | call | ret) & rb[0]);
      i_carry_in <= fw ? c : rb[1];
      i_zero_in <= fw ? z : rb[2];
      #1;
      `chk("pc", pc, o_pc)
      `chk("carry", cy, o_carry)
      `chk("zero", zf, o_zero)
      `chk("ack", ack, o_irq_ack)
      @(posedge i_mclk);
      i_irq_enter <= 1'b0;
      #1;
      ad = ins[1] ? regs[ix] : {3'b000, ix};
      si = ins[1] ? regs[ix][4:0] : ix;
      if (io && !sub[2]) begin
         `chk("rd", sub[0], o_port_rd)
         `chk("addr", ad, o_port_addr)
         `chk("wr", !sub[0], o_port_wr)
      end
      if (io && !sub[2] && !sub[0]) `chk("wdata", regs[rd], o_port_wdata)
      if (!io || sub[2]) `chk("wr", 1'b0, o_port_wr)
      if (!io || sub[2]) `chk("rd", 1'b0, o_port_rd)
      `chk("xrd", 1'b0, o_xmem_rd)
      `chk("xwr", 1'b0, o_xmem_wr)
      @(posedge i_mclk);
      if (irq) begin
         shc = cy;
         shz = zf;
         ack = 1'b1;
      end
      if (io) begin
         case (sub)
            mfd_pkg::SUB_PRD, mfd_pkg::SUB_PRDI: regs[rd] = pm[ad];
            mfd_pkg::SUB_PWR, mfd_pkg::SUB_PWRI: pm[ad] = regs[rd];
            mfd_pkg::SUB_SLD, mfd_pkg::SUB_SLDI: regs[rd] = scr[si];
            default: scr[si] = regs[rd];
         endcase
      end
      if (call && (ins[17:10] == mfd_pkg::OP_CALL || !cy)) begin
         stk[sp] = pc + 10'h001;
         sp = sp + 4'h1;
         pc = pc + ins[9:0];
      end else if (ret) begin
         sp = sp - 4'h1;
         pc = stk[sp];
         if (ins[0]) begin
            cy = shc;
            zf = shz;
            ack = 1'b0;
         end
      end else begin
         pc = pc + 10'h001;
         cy = fw ? c : cy;
         zf = fw ? z : zf;
      end
   endtask
   // counts and verdict, then stop
   task automatic conclude();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   // hang guard
   initial begin
      #100_000;
      mismatches++;
      conclude();
   end
   // main sequence
   initial begin
      rng = 32'h0000_f671;
      {i_rst_n, i_irq_enter, i_flag_wr, i_carry_in, i_zero_in, i_instr} = '0;
      {pc, sp, cy, zf, ack, mismatches, check_count} = '0;
      for (int i = 0; i < 256; i++) pm[i] = 8'(i * 7 + 3);
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 32; i++) run({mfd_pkg::OP_IO, 5'(i), 5'(31 - i), mfd_pkg::SUB_PRD});
      for (int i = 0; i < 32; i++) run({mfd_pkg::OP_IO, 5'(i), 5'(i), mfd_pkg::SUB_SST});
      for (int i = 0; i < 300; i++) begin
         r = xs();
         if (r[31:30] != 2'b11) run({mfd_pkg::OP_IO, r[12:0]});
         else if (r[29]) run({r[28] ? mfd_pkg::OP_CALL : mfd_pkg::OP_CALL_NC, r[9:0]});
         else if (r[28] && sp != 4'h0) run({mfd_pkg::OP_RET, 1'b0});
         else run(18'h0_0000, 1'b1, r[0], r[1]);
      end
      // stack deeper than its size wraps around
      for (int i = 0; i < 36; i++)
         run(i < 18 ? {mfd_pkg::OP_CALL, 10'(i * 37)} : {mfd_pkg::OP_RET, 1'b0});
      // interrupt entry, flag change, return with restore
      run(18'h0_0000, 1'b1, 1'b1, 1'b0);
      run(18'h0_0000, 1'b0, 1'b0, 1'b0, 1'b1);
      run(18'h0_0000, 1'b1, 1'b0, 1'b1);
      run({mfd_pkg::OP_CALL_NC, 10'h200});
      run({mfd_pkg::OP_RET, 1'b1});
      run({mfd_pkg::OP_CALL_NC, 10'h3ff});
      run(18'h0_0000);
      conclude();
   end
endmodule // mfd_core_bench

//--- tb/mfd_periph.sv
// Purpose: peripheral model on the far side of the port bus
// Assumes: strobes are one-cycle pulses from mfd_core
// Notes:   256 port locations, preset to a known pattern
`timescale 1ns/1ps
module mfd_periph (
   // clock
   input  wire logic       i_mclk,
   // port bus from the core
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   // answers to the core
   output logic [7:0]      o_rdata,
   output logic [7:0]      o_xdata
);
   logic [7:0] mem [256];
   logic [7:0] last_q = 8'h5a;
   logic [7:0] xcnt_q = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // preset pattern, mirrored by the bench model
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
   always @(posedge i_mclk) if (i_wr) mem[i_addr] <= i_wdata;
   always @(posedge i_mclk) if (i_rd) last_q <= mem[i_addr];
   // answer while selected, inverse when idle
   assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
   // unused external scratch data keeps moving
   always @(posedge i_mclk) xcnt_q <= xcnt_q + 8'h3b;
   assign o_xdata = xcnt_q;
endmodule // mfd_periph

//--- verilog/mfd_core.sv
// Purpose: decode and execute calls, returns, port and scratch accesses
// Assumes: instruction arrives from program memory addressed by o_pc
// Notes:   two cycles per instruction; other opcodes advance the pc and may load carry and zero
//
// Function
// - call_if_carry_clear pushes and jumps when carry clear
// - unconditional call pushes next, adds offset
// - return loads pc from stack, pops
// - interrupt_exit returns and restores shadow flags
// - direct port read into destination register
// - port_read_indexed uses register as port number
// - direct port write of named register
// - port_write_indexed uses index_register as port
// - scratch_load_direct from internal location 0-31
// - scratch_load_indexed from location given by register
// - scratch_store_direct writes register to location
// - these instructions never alter carry or zero, except interrupt_exit
// - scratch_store_indexed writes register at indexed location
// - port read drives address and read strobe
// - port write drives data, address, write strobe
// - external scratch uses own strobes and read data, shared address and write data buses
`timescale 1ns/1ps
module mfd_core #(
   parameter bit EXT_SCRATCH = 1'b0
) (
   // clock and reset
   input  wire logic                     i_mclk,
   input  wire logic                     i_rst_n,
   // program memory
   output logic [mfd_pkg::PCW-1:0]       o_pc,
   input  wire logic [mfd_pkg::IW-1:0]   i_instr,
   // port bus
   output logic [mfd_pkg::DW-1:0]        o_port_addr,
   output logic [mfd_pkg::DW-1:0]        o_port_wdata,
   output logic                          o_port_rd,
   output logic                          o_port_wr,
   input  wire logic [mfd_pkg::DW-1:0]   i_port_rdata,
   // external scratch memory
   output logic                          o_xmem_rd,
   output logic                          o_xmem_wr,
   input  wire logic [mfd_pkg::DW-1:0]   i_xmem_rdata,
   // interrupt entry from the surrounding core
   input  wire logic                     i_irq_enter,
   output logic                          o_irq_ack,
   // flags
   input  wire logic                     i_flag_wr,
   input  wire logic                     i_carry_in,
   input  wire logic                     i_zero_in,
   output logic                          o_carry,
   output logic                          o_zero
);
   ////////////////////////////////////////////////////////////////////////
   // state, stores
   mfd_pkg::mfd_state_t state_q;
   logic [mfd_pkg::PCW-1:0] pc_q;
   logic [mfd_pkg::PCW-1:0] stack_q [mfd_pkg::STACK_DEPTH];
   logic [mfd_pkg::SPW-1:0] sp_q;
   logic [mfd_pkg::DW-1:0]  regs_q [32];
   logic [mfd_pkg::DW-1:0]  scr_q [mfd_pkg::SCR_DEPTH];
   logic                    carry_q, zero_q, sh_carry_q, sh_zero_q, ack_q;
   logic [mfd_pkg::IW-1:0]  ir_q;

   // small helpers
   function automatic logic [mfd_pkg::SPW-1:0] sp_step(input logic [mfd_pkg::SPW-1:0] s,
                                                      input logic up);
      sp_step = up ? mfd_pkg::SPW'(s + 1'b1) : mfd_pkg::SPW'(s - 1'b1);
   endfunction
   function automatic logic [mfd_pkg::PCW-1:0] pc_next(input logic [mfd_pkg::PCW-1:0] p);
      pc_next = mfd_pkg::PCW'(p + 1'b1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode of the held instruction
   logic [4:0] rd, rb;
   logic [2:0] sub;
   logic is_io, is_call_nc, is_call, is_ret, is_interrupt_exit;
   logic do_call, do_prd, do_prdi, do_pwr, do_pwri, do_sld, do_sldi, do_sst, do_ssti;
   logic [mfd_pkg::DW-1:0] idx_val, rd_val;
   assign rd = ir_q[12:8];
   assign rb = ir_q[7:3];
   assign sub = ir_q[2:0];
   assign idx_val = regs_q[rb];
   assign rd_val = regs_q[rd];
   assign is_io = (ir_q[17:13] == mfd_pkg::OP_IO);
   assign is_call_nc = (ir_q[17:10] == mfd_pkg::OP_CALL_NC);
   assign is_call = (ir_q[17:10] == mfd_pkg::OP_CALL);
   assign is_ret = (ir_q[17:1] == mfd_pkg::OP_RET) && !ir_q[0];
   assign is_interrupt_exit = (ir_q[17:1] == mfd_pkg::OP_RET) && ir_q[0];
   assign do_call = is_call || (is_call_nc && !carry_q);
   assign do_prd = is_io && sub == mfd_pkg::SUB_PRD;
   assign do_prdi = is_io && sub == mfd_pkg::SUB_PRDI;
   assign do_pwr = is_io && sub == mfd_pkg::SUB_PWR;
   assign do_pwri = is_io && sub == mfd_pkg::SUB_PWRI;
   assign do_sld = is_io && sub == mfd_pkg::SUB_SLD;
   assign do_sldi = is_io && sub == mfd_pkg::SUB_SLDI;
   assign do_sst = is_io && sub == mfd_pkg::SUB_SST;
   assign do_ssti = is_io && sub == mfd_pkg::SUB_SSTI;

   logic exec;
   assign exec = (state_q == mfd_pkg::MFD_EXEC);

   ////////////////////////////////////////////////////////////////////////
   // port read strobe
   assign o_port_rd = exec && (do_prd || do_prdi);  // no false pop of a peripheral fifo
   assign o_port_wr = exec && (do_pwr || do_pwri);
   assign o_xmem_rd = exec && EXT_SCRATCH && do_sldi;
   assign o_xmem_wr = exec && EXT_SCRATCH && do_ssti;
   assign o_pc = pc_q;
   assign o_irq_ack = ack_q;
   assign o_carry = carry_q;
   assign o_zero = zero_q;

   // bus address and data, registered at the end of fetch
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_addr <= mfd_pkg::BYTE_RST;
         o_port_wdata <= mfd_pkg::BYTE_RST;
      end else if (state_q == mfd_pkg::MFD_FETCH) begin
         if (i_instr[1]) begin
            o_port_addr <= regs_q[i_instr[7:3]];
         end else begin
            o_port_addr <= {3'b000, i_instr[7:3]};
         end
         o_port_wdata <= regs_q[i_instr[12:8]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer and program counter
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= mfd_pkg::MFD_FETCH;
         pc_q <= mfd_pkg::PC_RST;
         ir_q <= '0;
      end else begin
         case (state_q)
            mfd_pkg::MFD_FETCH: begin
               ir_q <= i_instr;
               state_q <= mfd_pkg::MFD_EXEC;
            end
            mfd_pkg::MFD_EXEC: begin
               state_q <= mfd_pkg::MFD_FETCH;
               if (do_call) begin
                  pc_q <= mfd_pkg::PCW'(pc_q + ir_q[9:0]);
               end else if (is_ret || is_interrupt_exit) begin
                  pc_q <= stack_q[sp_step(sp_q, 1'b0)];
               end else begin
                  pc_q <= pc_next(pc_q);
               end
            end
            default: state_q <= mfd_pkg::MFD_FETCH;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp_q <= '0;
      end else if (exec && do_call) begin
         sp_q <= sp_step(sp_q, 1'b1);
      end else if (exec && (is_ret || is_interrupt_exit)) begin
         sp_q <= sp_step(sp_q, 1'b0);
      end
   end
   always_ff @(posedge i_mclk) begin
      if (exec && do_call) begin
         stack_q[sp_q] <= pc_next(pc_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags kept by these opcodes
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         carry_q <= 1'b0;
         zero_q <= 1'b0;
      end else if (exec && is_interrupt_exit) begin
         carry_q <= sh_carry_q;
         zero_q <= sh_zero_q;
      // alu flag results only count in exec, where ir_q is their opcode
      end else if (exec && i_flag_wr && !(is_io || is_call || is_call_nc || is_ret)) begin
         carry_q <= i_carry_in;
         zero_q <= i_zero_in;
      end
   end

   // shadow copies taken on interrupt entry
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sh_carry_q <= 1'b0;
         sh_zero_q <= 1'b0;
      end else if (i_irq_enter) begin
         sh_carry_q <= carry_q;
         sh_zero_q <= zero_q;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else if (i_irq_enter) begin
         ack_q <= 1'b1;                   // a new entry wins over a same-cycle exit
      end else if (exec && is_interrupt_exit) begin
         ack_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file writeback
   always_ff @(posedge i_mclk) begin
      if (exec) begin
         if (do_prd || do_prdi) begin
            regs_q[rd] <= i_port_rdata;
         end else if (do_sld) begin
            regs_q[rd] <= scr_q[rb];
         end else if (do_sldi) begin
            regs_q[rd] <= EXT_SCRATCH ? i_xmem_rdata : scr_q[idx_val[4:0]];
         end
      end
   end

   // internal scratch stores
   always_ff @(posedge i_mclk) begin
      if (exec) begin
         if (do_sst) begin
            scr_q[rb] <= rd_val;
         end else if (do_ssti && !EXT_SCRATCH) begin
            scr_q[idx_val[4:0]] <= rd_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   // call taken only on clear carry
   call_nc_jump_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && is_call_nc && carry_q |=> pc_q == pc_next($past(pc_q)))
      else $error("conditional call taken with carry set");
   call_target_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && is_call |=> pc_q == mfd_pkg::PCW'($past(pc_q) + $past(ir_q[9:0])))
      else $error("call target wrong");
   ret_pop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && (is_ret || is_interrupt_exit) |=> sp_q == mfd_pkg::SPW'($past(sp_q) - 1'b1))
      else $error("return did not pop");
   interrupt_exit_flags_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && is_interrupt_exit |=> carry_q == $past(sh_carry_q) && zero_q == $past(sh_zero_q))
      else $error("flags not restored");
   flags_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && is_io && !i_irq_enter |=> $stable(carry_q) && $stable(zero_q))
      else $error("flags changed by io opcode");
   port_rd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_port_rd |=> !o_port_rd)
      else $error("read strobe longer than one cycle");
   port_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_port_wr |-> o_port_wdata == rd_val)
      else $error("write data not the named register");
   ack_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && is_interrupt_exit && !i_irq_enter |=> !o_irq_ack)
      else $error("acknowledge still high after exit");
   ack_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_irq_enter |=> o_irq_ack)
      else $error("acknowledge not raised on entry");
   stack_push_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && do_call |=> stack_q[$past(sp_q)] == pc_next($past(pc_q)))
      else $error("wrong return address pushed");
   scr_rd_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      exec && is_io && sub[2] |-> !o_port_rd)
      else $error("port read strobe on scratch access");
endmodule // mfd_core

//--- verilog/mfd_pkg.sv
// Purpose: constants for the flow and port/scratch decode-execute block
// Assumes: 18-bit instruction words, 8-bit data, 10-bit program counter
// Notes:   opcodes, field positions, sizes and reset values
package mfd_pkg;
   localparam int IW = 18;
   localparam int PCW = 10;
   localparam int DW = 8;
   localparam int RIX = 5;
   localparam int STACK_DEPTH = 16;
   localparam int SPW = 4;
   localparam int SCR_DEPTH = 32;
   localparam int EXT_SCR_DEPTH = 256;
   // opcode prefixes
   localparam logic [7:0] OP_CALL_NC = 8'b1101_1011;
   localparam logic [7:0] OP_CALL = 8'b1101_1100;
   localparam logic [16:0] OP_RET = 17'b1_1101_0000_0000_0000;
   localparam logic [4:0] OP_IO = 5'b11110;
   // io sub-op codes in bits 2..0
   localparam logic [2:0] SUB_PRD = 3'b001;
   localparam logic [2:0] SUB_PRDI = 3'b011;
   localparam logic [2:0] SUB_PWR = 3'b000;
   localparam logic [2:0] SUB_PWRI = 3'b010;
   localparam logic [2:0] SUB_SLD = 3'b101;
   localparam logic [2:0] SUB_SLDI = 3'b111;
   localparam logic [2:0] SUB_SST = 3'b100;
   localparam logic [2:0] SUB_SSTI = 3'b110;
   // reset values
   localparam logic [PCW-1:0] PC_RST = 10'h000;
   localparam logic [DW-1:0] BYTE_RST = 8'h00;
   typedef enum {MFD_FETCH, MFD_EXEC} mfd_state_t;
endpackage
